// *** hw/flash_card_ecc_strobe.sv ***
// flash_card_ecc_strobe: APB slave, card strobes and running byte ECC
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - ECC enable bit set makes every card data access update the ECC.
// - interface enable bit routes data port to card bus with strobes.
// - wait field stretches strobes by 0, 1, 4 or 8 cycles.
// - readable 8-bit counter counts ECC byte operations.
// - byte counter clears when ECC enable is set and on overflow.
// - each card data access with ECC enabled does exactly one byte ECC update.
// - ECC registers follow port accesses only while ECC is enabled.
// - any write to the clear register zeroes all three ECC registers.
// - high result register gives the byte position of a single error.
// - low result bits 2..0 give the bit position of that error.
// - low result bits 4..3: 00 none, 01 single, 1x multiple error.
module flash_card_ecc_strobe (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] card_data_in,
    output flash_card_pkg::card_drive_t card
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STROBE,
        ST_SETTLE,
        ST_RELEASE,
        ST_DONE
    } port_state_t;
    port_state_t state;
    logic [7:0] card_if_control;
    logic [7:0] ecc_byte_counter;
    flash_card_pkg::ecc_word_t parity;
    logic [7:0] ecc_result_byte_pos;
    logic [7:0] ecc_result_bit_info;
    logic [7:0] data_meta;
    logic [7:0] data_sync;
    logic [3:0] cnt;
    logic acc_write;
    logic acc_ecc;
    logic [7:0] acc_byte;
    flash_card_pkg::ecc_word_t next_ecc;
    flash_card_pkg::ecc_result_t cmp_res;
    logic setup;
    logic access;
    logic wr_acc;
    logic sel_data;
    logic sel_ctrl;
    logic sel_cnt;
    logic sel_high;
    logic sel_low;
    logic sel_ext;
    logic sel_clr;
    logic sel_rbyte;
    logic sel_rbit;
    logic sel_cmp;
    logic mapped;
    logic ecc_step;
    function automatic logic [3:0] wait_cycles(input logic [1:0] code);
        case (code)
            2'b00: return flash_card_pkg::WAIT_C0;
            2'b01: return flash_card_pkg::WAIT_C1;
            2'b10: return flash_card_pkg::WAIT_C2;
            default: return flash_card_pkg::WAIT_C3;
        endcase
    endfunction
    function automatic logic hit(input logic [31:0] a,
                                 input logic [23:0] idx);
        return a == flash_card_pkg::byte_addr(idx);
    endfunction
    assign sel_data = hit(paddr, flash_card_pkg::DATA_IDX);
    assign sel_ctrl = hit(paddr, flash_card_pkg::CTRL_IDX);
    assign sel_cnt = hit(paddr, flash_card_pkg::CNT_IDX);
    assign sel_high = hit(paddr, flash_card_pkg::PHIGH_IDX);
    assign sel_low = hit(paddr, flash_card_pkg::PLOW_IDX);
    assign sel_ext = hit(paddr, flash_card_pkg::PEXT_IDX);
    assign sel_clr = hit(paddr, flash_card_pkg::CLR_IDX);
    assign sel_rbyte = hit(paddr, flash_card_pkg::RBYTE_IDX);
    assign sel_rbit = hit(paddr, flash_card_pkg::RBIT_IDX);
    assign sel_cmp = hit(paddr, flash_card_pkg::CMP_IDX);
    assign mapped = sel_data | sel_ctrl | sel_cnt | sel_high | sel_low
                    | sel_ext | sel_clr | sel_rbyte | sel_rbit | sel_cmp;
    assign setup = psel & ~penable;
    // data port holds the bus until the card cycle has finished
    assign pready = psel & penable & (~sel_data | (state == ST_DONE));
    assign access = psel & penable & pready;
    assign wr_acc = access & pwrite;
    assign pslverr = access & ~mapped;
    assign ecc_step = (state == ST_DONE) & acc_ecc;
    ecc_hamming u_ecc (
        .data(acc_byte),
        .addr(ecc_byte_counter),
        .cur(parity),
        .stored(pwdata[23:0]),
        .next_ecc(next_ecc),
        .result(cmp_res)
    );
    // card pins come from another domain: two flops before use
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_meta <= 8'h00;
            data_sync <= 8'h00;
        end else begin
            data_meta <= card_data_in;
            data_sync <= data_meta;
        end
    end

    // card cycle sequencer; latch, command and chip enable stay software's
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            acc_write <= 1'b0;
            acc_ecc <= 1'b0;
            acc_byte <= 8'h00;
            card <= '{dout: 8'h00, doe: 1'b0,
                      wr_strobe_low: 1'b1, rd_strobe_low: 1'b1};
        end else begin
            case (state)
                ST_IDLE: begin
                    if (setup && sel_data) begin
                        acc_write <= pwrite;
                        acc_byte <= pwdata[7:0];
                        cnt <= wait_cycles(
                            card_if_control[flash_card_pkg::WAIT_LSB+:2]);
                        // ecc follows data port accesses only while the ECC enable bit is set, bus on or off
                        acc_ecc <= card_if_control[
                            flash_card_pkg::ECC_EN_BIT];
                        if (card_if_control[flash_card_pkg::IF_EN_BIT]) begin
                            state <= ST_STROBE;
                            card.dout <= pwdata[7:0];
                            card.doe <= pwrite;
                            card.wr_strobe_low <= ~pwrite;
                            card.rd_strobe_low <= pwrite;
                        end else begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_STROBE: begin
                    if (cnt == 4'h0) begin
                        if (acc_write) begin
                            state <= ST_RELEASE;
                            card.wr_strobe_low <= 1'b1;
                        end else begin
                            state <= ST_SETTLE;
                            cnt <= flash_card_pkg::SETTLE_CYC - 4'h1;
                        end
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                ST_SETTLE: begin
                    if (cnt == 4'h0) begin
                        state <= ST_DONE;
                        acc_byte <= data_sync;
                        card.rd_strobe_low <= 1'b1;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                ST_RELEASE: begin
                    // data held one cycle past the write strobe edge
                    state <= ST_DONE;
                    card.doe <= 1'b0;
                end
                ST_DONE: begin
                    if (access) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            card_if_control <= flash_card_pkg::REG_RST;
        end else if (wr_acc && sel_ctrl) begin
            card_if_control <= pwdata[7:0];
        end
    end

    // counter doubles as the byte address inside the 256-byte block
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ecc_byte_counter <= flash_card_pkg::REG_RST;
        end else if (wr_acc && sel_ctrl
                     && pwdata[flash_card_pkg::ECC_EN_BIT]
                     && !card_if_control[flash_card_pkg::ECC_EN_BIT]) begin
            ecc_byte_counter <= 8'h00;
        end else if (wr_acc && sel_cnt) begin
            ecc_byte_counter <= pwdata[7:0];
        end else if (ecc_step) begin
            // wrap past 8'hff is the overflow clear
            ecc_byte_counter <= ecc_byte_counter + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            parity <= '0;
        end else if (wr_acc && sel_clr) begin
            parity <= '0;
        end else if (ecc_step) begin
            parity <= next_ecc;
        end else if (wr_acc) begin
            if (sel_high) begin
                parity.high <= pwdata[7:0];
            end
            if (sel_low) begin
                parity.low <= pwdata[7:0];
            end
            if (sel_ext) begin
                parity.ext <= pwdata[7:0];
            end
        end
    end
    // compare: stored ECC is written as {ext, high, low} in one word
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ecc_result_byte_pos <= flash_card_pkg::REG_RST;
            ecc_result_bit_info <= flash_card_pkg::REG_RST;
        end else if (wr_acc && sel_cmp) begin
            ecc_result_byte_pos <= cmp_res.byte_pos;
            ecc_result_bit_info <= {3'b000, cmp_res.cls,
                                    cmp_res.bit_pos};
        end else if (wr_acc) begin
            if (sel_rbyte) begin
                ecc_result_byte_pos <= pwdata[7:0];
            end
            if (sel_rbit) begin
                ecc_result_bit_info <= pwdata[7:0];
            end
        end
    end
    // register reads sampled in setup; data port read filled at capture
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (state == ST_SETTLE && cnt == 4'h0) begin
            prdata <= {24'h00_0000, data_sync};
        end else if (setup) begin
            prdata <= 32'h0000_0000;
            if (sel_ctrl) begin
                prdata[7:0] <= card_if_control;
            end
            if (sel_cnt) begin
                prdata[7:0] <= ecc_byte_counter;
            end
            if (sel_high) begin
                prdata[7:0] <= parity.high;
            end
            if (sel_low) begin
                prdata[7:0] <= parity.low;
            end
            if (sel_ext) begin
                prdata[7:0] <= parity.ext;
            end
            if (sel_rbyte) begin
                prdata[7:0] <= ecc_result_byte_pos;
            end
            if (sel_rbit) begin
                prdata[7:0] <= ecc_result_bit_info;
            end
        end
    end
    // helper: length of the current strobe low time
    logic [4:0] low_len;
    logic [3:0] wait_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_len <= 5'h00;
            wait_q <= 4'h0;
        end else begin
            if (setup && sel_data) begin
                wait_q <= wait_cycles(
                    card_if_control[flash_card_pkg::WAIT_LSB+:2]);
            end
            if (!card.wr_strobe_low || !card.rd_strobe_low) begin
                low_len <= low_len + 5'h01;
            end else begin
                low_len <= 5'h00;
            end
        end
    end

    wr_strobe_len_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(card.wr_strobe_low) |->
            low_len == {1'b0, wait_q} + 5'h01)
        else $error("write strobe length does not match wait code");
    rd_strobe_len_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(card.rd_strobe_low) |->
            low_len == {1'b0, wait_q} + 5'h01 + {1'b0,
                flash_card_pkg::SETTLE_CYC})
        else $error("read strobe length does not match wait code");
    strobe_on_access_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_IDLE && setup && sel_data
            && card_if_control[flash_card_pkg::IF_EN_BIT])
        |=> (card.wr_strobe_low != card.rd_strobe_low)
            && (card.doe == !card.wr_strobe_low))
        else $error("card access gave no single strobe");
    no_strobe_off_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_IDLE && setup && sel_data
            && !card_if_control[flash_card_pkg::IF_EN_BIT])
        |=> (card.wr_strobe_low && card.rd_strobe_low
            && !card.doe)[*2])
        else $error("strobe while interface disabled");
    ecc_one_step_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_DONE && access && acc_ecc)
        |=> ecc_byte_counter == $past(ecc_byte_counter) + 8'h01
            ##1 $stable(ecc_byte_counter))
        else $error("data access did not do exactly one ECC step");
    ecc_idle_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_DONE && !acc_ecc)
        |=> $stable(parity) && $stable(ecc_byte_counter))
        else $error("ECC moved while disabled");
    cnt_clear_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_acc && sel_ctrl && pwdata[0] && !card_if_control[0])
        |=> ecc_byte_counter == 8'h00)
        else $error("byte counter not cleared on ECC enable");
    ecc_clear_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_acc && sel_clr) |=> parity == 24'h00_0000)
        else $error("ECC registers not cleared");
    single_error_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_acc && sel_cmp && (pwdata[23:0] ^ parity) == 24'h54_5555)
        |=> ecc_result_byte_pos == 8'h00
            && ecc_result_bit_info == 8'h08)
        else $error("byte 0 bit 0 error not located");
    no_error_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_acc && sel_cmp && pwdata[23:0] == parity)
        |=> ecc_result_bit_info[4:3] == 2'b00)
        else $error("clean compare reported an error");
    last_byte_a: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wr_acc && sel_cmp && (pwdata[23:0] ^ parity) == 24'ha8_aaaa)
        |=> ecc_result_byte_pos == 8'hff
            && ecc_result_bit_info == 8'h0f)
        else $error("byte 255 bit 7 error not located");
endmodule

// *** hw/flash_card_pkg.sv ***
// package: register map, field layout and shared types of the flash card block
package flash_card_pkg;
    // register indices; byte address is four times the index
    localparam logic [23:0] CMP_IDX = 24'h3f0056;
    localparam logic [23:0] DATA_IDX = 24'h3f0057;
    localparam logic [23:0] CTRL_IDX = 24'h3f0058;
    localparam logic [23:0] CNT_IDX = 24'h3f0059;
    localparam logic [23:0] PHIGH_IDX = 24'h3f005a;
    localparam logic [23:0] PLOW_IDX = 24'h3f005b;
    localparam logic [23:0] PEXT_IDX = 24'h3f005c;
    localparam logic [23:0] CLR_IDX = 24'h3f005d;
    localparam logic [23:0] RBYTE_IDX = 24'h3f005e;
    localparam logic [23:0] RBIT_IDX = 24'h3f005f;

    localparam int ECC_EN_BIT = 0;
    localparam int IF_EN_BIT = 1;
    localparam int WAIT_LSB = 2;

    localparam logic [7:0] REG_RST = 8'h00;

    // strobe stretch for wait codes 00..11
    localparam logic [3:0] WAIT_C0 = 4'h0;
    localparam logic [3:0] WAIT_C1 = 4'h1;
    localparam logic [3:0] WAIT_C2 = 4'h4;
    localparam logic [3:0] WAIT_C3 = 4'h8;
    // extra strobe cycles so read data clears the pin synchroniser
    localparam logic [3:0] SETTLE_CYC = 4'h2;

    localparam logic [1:0] CLS_NONE = 2'h0;
    localparam logic [1:0] CLS_ONE = 2'h1;
    localparam logic [1:0] CLS_MULTI = 2'h2;

    typedef struct packed {
        logic [7:0] dout;
        logic doe;
        logic wr_strobe_low;
        logic rd_strobe_low;
    } card_drive_t;

    typedef struct packed {
        logic [7:0] ext;
        logic [7:0] high;
        logic [7:0] low;
    } ecc_word_t;

    typedef struct packed {
        logic [7:0] byte_pos;
        logic [2:0] bit_pos;
        logic [1:0] cls;
    } ecc_result_t;

    function automatic logic [31:0] byte_addr(input logic [23:0] idx);
        return {6'h00, idx, 2'b00};
    endfunction
endpackage

// *** hw/ecc_hamming.sv ***
// ecc_hamming: one-byte line/column parity update and syndrome decode
`timescale 1ns/1ps
module ecc_hamming (
    input wire logic [7:0] data,
    input wire logic [7:0] addr,
    input wire flash_card_pkg::ecc_word_t cur,
    input wire flash_card_pkg::ecc_word_t stored,
    output flash_card_pkg::ecc_word_t next_ecc,
    output flash_card_pkg::ecc_result_t result
);
    logic [15:0] lp;
    logic [5:0] cp;
    logic [15:0] slp;
    logic [5:0] scp;
    logic pairs_ok;

    // line parity pairs per address bit, column parity pairs per bit index
    always_comb begin
        lp = {cur.high, cur.low};
        cp = cur.ext[7:2];
        if (^data) begin
            for (int i = 0; i < 8; i++) begin
                if (addr[i]) begin
                    lp[2*i+1] = ~lp[2*i+1];
                end else begin
                    lp[2*i] = ~lp[2*i];
                end
            end
        end
        cp[0] = cp[0] ^ data[0] ^ data[2] ^ data[4] ^ data[6];
        cp[1] = cp[1] ^ data[1] ^ data[3] ^ data[5] ^ data[7];
        cp[2] = cp[2] ^ data[0] ^ data[1] ^ data[4] ^ data[5];
        cp[3] = cp[3] ^ data[2] ^ data[3] ^ data[6] ^ data[7];
        cp[4] = cp[4] ^ (^data[3:0]);
        cp[5] = cp[5] ^ (^data[7:4]);
        next_ecc = {cp, 2'b00, lp};
    end

    // every pair split means one flipped data bit; odd members locate it
    always_comb begin
        slp = {stored.high, stored.low} ^ {cur.high, cur.low};
        scp = stored.ext[7:2] ^ cur.ext[7:2];
        pairs_ok = 1'b1;
        result = '0;
        for (int i = 0; i < 8; i++) begin
            pairs_ok = pairs_ok & (slp[2*i] ^ slp[2*i+1]);
        end
        for (int j = 0; j < 3; j++) begin
            pairs_ok = pairs_ok & (scp[2*j] ^ scp[2*j+1]);
        end
        if ({slp, scp} == 22'h0) begin
            result.cls = flash_card_pkg::CLS_NONE;
        end else if (pairs_ok) begin
            result.cls = flash_card_pkg::CLS_ONE;
            for (int i = 0; i < 8; i++) begin
                result.byte_pos[i] = slp[2*i+1];
            end
            for (int j = 0; j < 3; j++) begin
                result.bit_pos[j] = scp[2*j+1];
            end
        end else begin
            result.cls = flash_card_pkg::CLS_MULTI;
        end
    end
endmodule

// *** verif/card_model.sv ***
// card_model: behavioural flash card on the far side of the data pins
`timescale 1ns/1ps
module card_model (
    input wire flash_card_pkg::card_drive_t card,
    output logic [7:0] card_data_in,
    output logic [7:0] last_wr
);
    initial last_wr = 8'h00;
    // the card takes the bus byte as its write strobe goes high again
    always @(posedge card.wr_strobe_low) begin
        last_wr <= card.dout;
    end
    // no pull on the bus: an idle card shows the inverse so stale data fails
    assign card_data_in = (card.rd_strobe_low === 1'b0) ? last_wr : ~last_wr;
endmodule

// *** verif/testbench.sv ***
// testbench: register, strobe and ecc scenarios for the flash card block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
$display("[ERR] %s exp %h got %h", n, e, g); miscompares++; end end
module testbench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] card_data_in;
    logic [7:0] last_wr;
    flash_card_pkg::card_drive_t card;
    int miscompares = 0;
    int compares = 0;
    int wr_low = 0;
    int rd_low = 0;
    logic [31:0] rd;
    logic er;

    flash_card_ecc_strobe dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .card_data_in(card_data_in), .card(card));
    card_model partner (.card(card), .card_data_in(card_data_in),
        .last_wr(last_wr));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (card.wr_strobe_low === 1'b0) wr_low++;
        if (card.rd_strobe_low === 1'b0) rd_low++;
    end

    task automatic apb(input logic wr, input logic [23:0] idx,
                       input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {6'h00, idx, 2'b00};
        pwdata <= wd;
        wr_low = 0;
        rd_low = 0;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK("pready", 1'b1, pready)
    endtask

    task automatic rchk(input logic [23:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 32'h0);
        `CHK("reg", {24'h0, e}, rd)
    endtask

    task automatic t_reset;
        logic [23:0] idx[8] = '{24'h3f0058, 24'h3f0059, 24'h3f005a,
            24'h3f005b, 24'h3f005c, 24'h3f005d, 24'h3f005e, 24'h3f005f};
        foreach (idx[i]) rchk(idx[i], 8'h00);
        apb(1'b0, 24'h3f0050, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
    endtask

    task automatic t_wait;
        int wt[4] = '{0, 1, 4, 8};
        for (int w = 0; w < 4; w++) begin
            apb(1'b1, 24'h3f0058, {28'h0, w[1:0], 2'b10});
            apb(1'b1, 24'h3f0057, 32'h000000a0 + w);
            `CHK("wr strobe len", 1 + wt[w], wr_low)
            `CHK("card byte", 8'ha0 + w[7:0], last_wr)
        end
        apb(1'b1, 24'h3f0058, 32'h00000002);
        apb(1'b0, 24'h3f0057, 32'h0);
        `CHK("rd byte", {24'h0, last_wr}, rd)
        `CHK("rd strobe len", 3, rd_low)
    endtask

    task automatic t_ecc;
        apb(1'b1, 24'h3f0059, 32'h00000005);
        rchk(24'h3f0059, 8'h05);
        apb(1'b1, 24'h3f0058, 32'h00000003);
        rchk(24'h3f0059, 8'h00);
        apb(1'b1, 24'h3f0057, 32'h00000001);
        rchk(24'h3f0059, 8'h01);
        rchk(24'h3f005b, 8'h55);
        rchk(24'h3f005a, 8'h55);
        rchk(24'h3f005c, 8'h54);
        apb(1'b1, 24'h3f0056, 32'h00000000);
        rchk(24'h3f005e, 8'h00);
        rchk(24'h3f005f, 8'h08);
        // one stored low bit off leaves a parity pair unsplit
        apb(1'b1, 24'h3f0056, 32'h00000001);
        apb(1'b0, 24'h3f005f, 32'h0);
        `CHK("multi class", 2'b10, rd[4:3])
        apb(1'b1, 24'h3f0056, 32'h00545555);
        apb(1'b0, 24'h3f005f, 32'h0);
        `CHK("none class", 2'b00, rd[4:3])
        // every odd pair member split: byte 255, bit 7
        apb(1'b1, 24'h3f0056, 32'h00fcffff);
        rchk(24'h3f005e, 8'hff);
        rchk(24'h3f005f, 8'h0f);
        apb(1'b1, 24'h3f005d, 32'h0000005a);
        rchk(24'h3f005a, 8'h00);
        rchk(24'h3f005b, 8'h00);
        rchk(24'h3f005c, 8'h00);
        // ecc off: port traffic must leave parity and count alone
        apb(1'b1, 24'h3f0058, 32'h00000002);
        apb(1'b1, 24'h3f0057, 32'h000000ff);
        rchk(24'h3f005b, 8'h00);
        rchk(24'h3f0059, 8'h01);
    endtask

    task automatic t_wrap;
        apb(1'b1, 24'h3f0058, 32'h00000003);
        for (int i = 0; i < 255; i++) apb(1'b1, 24'h3f0057, 32'h0);
        rchk(24'h3f0059, 8'hff);
        apb(1'b1, 24'h3f0057, 32'h0);
        rchk(24'h3f0059, 8'h00);
    endtask

    task automatic conclude;
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // latch, command and chip-enable lines stay with software
    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_wait();
        t_ecc();
        t_wrap();
        conclude();
    end

    initial begin
        #2000000;
        miscompares++;
        conclude();
    end
endmodule
